/* File: pesm_consts.svh */
// constants for the performance event select map
`ifndef PESM_CONSTS_SVH
`define PESM_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses on apb)
// ****************************************************************
`define PESM_OFF_SELECT_BASE    12'h000
`define PESM_OFF_CONFIG_BASE    12'h020
`define PESM_OFF_COUNT_BASE     12'h040
`define PESM_OFF_IRQ_STATUS     12'h060
`define PESM_OFF_IRQ_MASK       12'h064
`define PESM_OFF_MISS_COUNT     12'h068

// ****************************************************************
// event select register indices
// ****************************************************************
`define PESM_IDX_BRANCH_A       0
`define PESM_IDX_BRANCH_B       1
`define PESM_IDX_TRANSL_A       2
`define PESM_IDX_TRANSL_B       3
`define PESM_IDX_DCACHE_A       4
`define PESM_IDX_DCACHE_B       5
`define PESM_IDX_STADDR_A       6
`define PESM_IDX_STADDR_B       7
`define PESM_NUM_SEL            8
`define PESM_NUM_CNT            8

// ****************************************************************
// field positions
// ****************************************************************
`define PESM_SEL_CODE_HI        31
`define PESM_SEL_CODE_LO        25
`define PESM_SEL_MASK_HI        24
`define PESM_SEL_MASK_LO        9
`define PESM_CFG_CSEL_HI        15
`define PESM_CFG_CSEL_LO        13
`define PESM_CFG_ENABLE         12
`define PESM_SEL_WR_MASK        32'hFFFFFE00
`define PESM_CFG_WR_MASK        32'h0000F000
`define PESM_RESET_WORD         32'h00000000

// ****************************************************************
// event codes and counter config select codes
// ****************************************************************
`define PESM_CODE_BRANCH_FETCH  7'h03
`define PESM_CODE_TRANSL_REF    7'h18
`define PESM_CODE_DCACHE_CANCEL 7'h02
`define PESM_CODE_SPLIT_DONE    7'h08
`define PESM_CODE_LOAD_REPLAY   7'h04
`define PESM_CSEL_BRANCH        3'h0
`define PESM_CSEL_TRANSL        3'h3
`define PESM_CSEL_DCACHE        3'h5
`define PESM_CSEL_STADDR        3'h2

// ****************************************************************
// mask bit positions
// ****************************************************************
`define PESM_MB_TRACE_ABSENT    0
`define PESM_MB_TR_HIT          0
`define PESM_MB_TR_MISS         1
`define PESM_MB_TR_UC_HIT       2
`define PESM_MB_STBUF_FULL      2
`define PESM_MB_ALIAS           3
`define PESM_MB_LOAD_SPLIT      0
`define PESM_MB_STORE_SPLIT     1
`define PESM_MB_DIVIDED_LOAD    1

`endif

/* File: pesm_pkg.sv */
// types for the performance event select map
package pesm_pkg;
  typedef logic [31:0] pesm_word_t;
  typedef logic [15:0] pesm_mask_t;
  typedef logic [6:0]  pesm_code_t;
  typedef logic [2:0]  pesm_csel_t;
endpackage

/* File: pesm_counter.sv */
// one 32-bit event counter with load and overflow pulse
`timescale 1ns/100ps
`include "pesm_consts.svh"
module pesm_counter (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              load,
  input  wire pesm_pkg::pesm_word_t load_val,
  input  wire logic              inc,
  output pesm_pkg::pesm_word_t   count_q,
  output logic                   ovf
);

  // software load wins over a same-cycle increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `PESM_RESET_WORD;
    end else if (load) begin
      count_q <= load_val;
    end else if (inc) begin
      count_q <= count_q + 32'h00000001;
    end
  end

  assign ovf = inc & ~load & (&count_q);

endmodule // pesm_counter

/* File: pesm_top.sv */
// performance event select map: apb registers, event qualify, counters
//
// Operation
// R1 - branch fetch event: code 03H, select 00H, branch regs feed counters 0-3
// R2 - fetch mask in select bits 24:9, bit 0 picks trace lookup misses
// R3 - translation event: code 18H, select 03H, hit/miss/uncacheable hit bits
// R4 - translation references counted as 4-KByte lookups whatever the page size
// R5 - software may use page walk miss event for a conservative miss count
// R6 - cache cancel: code 02H, select 05H, cache address regs feed 8-11
// R7 - cancel mask bit 2 counts replays for lack of store buffer
// R8 - cancel mask bit 3 counts 64K aliasing conflicts
// R9 - all cache miss count also counts uncacheable memory accesses
// R10 - split completion: code 08H, select 02H, store address regs feed 8-11
// R11 - completion bit 0 counts load splits except uncacheable or combining loads
// R12 - completion bit 1 counts every completed split store
// R13 - load replay: code 04H, select 02H, bit 1 split loads, counters 8-11
// R14 - software uses second store address reg for at-retirement replay counting
// R15 - event code in select bits 31:25, config select in bits 15:13
// R16 - enabled counter counts event when any set mask bit matches
`timescale 1ns/100ps
`include "pesm_consts.svh"
module pesm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        branch_predictor_fetch_event,
  input  wire logic        trace_lookup_absent,
  input  wire logic        instr_translation_lookup_event,
  input  wire logic        translation_hit,
  input  wire logic        translation_miss,
  input  wire logic        uncacheable_translation_found,
  input  wire logic        store_buffer_exhausted,
  input  wire logic        alias_conflict,
  input  wire logic        load_split_done,
  input  wire logic        load_split_uc_wc,
  input  wire logic        store_split_done,
  input  wire logic        divided_load,
  input  wire logic        cache_miss,
  input  wire logic        uncacheable_access
);

  // ****************************************************************
  // storage
  // ****************************************************************
  pesm_pkg::pesm_word_t sel_q  [`PESM_NUM_SEL];
  pesm_pkg::pesm_word_t cfg_q  [`PESM_NUM_CNT];
  pesm_pkg::pesm_word_t cnt_q  [`PESM_NUM_CNT];
  pesm_pkg::pesm_word_t miss_q;
  logic [7:0]           irq_status_q;
  logic [7:0]           irq_mask_q;
  logic [7:0]           ovf;
  logic [7:0]           cnt_inc;
  logic [7:0]           cnt_load;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic        setup_ph;
  logic        wr_access;
  logic [11:0] region;
  logic [2:0]  widx;
  logic        in_sel;
  logic        in_cfg;
  logic        in_cnt;
  logic        at_status;
  logic        at_mask;
  logic        at_miss;
  logic        aligned;

  assign setup_ph  = psel & ~penable;
  assign wr_access = psel & penable & pwrite & ~pslverr_q;
  assign region    = {paddr[11:5], 5'h00};
  assign widx      = paddr[4:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign in_sel    = aligned & (region == `PESM_OFF_SELECT_BASE);
  assign in_cfg    = aligned & (region == `PESM_OFF_CONFIG_BASE);
  assign in_cnt    = aligned & (region == `PESM_OFF_COUNT_BASE);
  assign at_status = (paddr == `PESM_OFF_IRQ_STATUS);
  assign at_mask   = (paddr == `PESM_OFF_IRQ_MASK);
  assign at_miss   = (paddr == `PESM_OFF_MISS_COUNT);

  // zero wait states; data was latched in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // read data and error, captured in setup phase
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= `PESM_RESET_WORD;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      pslverr_q <= ~(in_sel | in_cfg | in_cnt | at_status | at_mask | at_miss);
      if (pwrite) begin
        prdata_q <= `PESM_RESET_WORD;
      end else if (in_sel) begin
        prdata_q <= sel_q[widx];
      end else if (in_cfg) begin
        prdata_q <= cfg_q[widx];
      end else if (in_cnt) begin
        prdata_q <= cnt_q[widx];
      end else if (at_status) begin
        prdata_q <= {24'h000000, irq_status_q};
      end else if (at_mask) begin
        prdata_q <= {24'h000000, irq_mask_q};
      end else if (at_miss) begin
        prdata_q <= miss_q;
      end else begin
        prdata_q <= `PESM_RESET_WORD;
      end
    end
  end

  // ****************************************************************
  // event select registers
  // ****************************************************************
  // R15 - code and mask fields kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PESM_NUM_SEL; i++) begin
        sel_q[i] <= `PESM_RESET_WORD;
      end
    end else if (wr_access & in_sel) begin
      sel_q[widx] <= pwdata & `PESM_SEL_WR_MASK;
    end
  end

  // ****************************************************************
  // counter config registers
  // ****************************************************************
  // R15 - select field kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PESM_NUM_CNT; i++) begin
        cfg_q[i] <= `PESM_RESET_WORD;
      end
    end else if (wr_access & in_cfg) begin
      cfg_q[widx] <= pwdata & `PESM_CFG_WR_MASK;
    end
  end

  // ****************************************************************
  // qualifying conditions, one mask-bit vector per event code
  // ****************************************************************
  pesm_pkg::pesm_mask_t cond_branch;
  pesm_pkg::pesm_mask_t cond_transl;
  pesm_pkg::pesm_mask_t cond_dcache;
  pesm_pkg::pesm_mask_t cond_split;
  pesm_pkg::pesm_mask_t cond_replay;

  always_comb begin
    cond_branch = 16'h0000;
    cond_transl = 16'h0000;
    cond_dcache = 16'h0000;
    cond_split  = 16'h0000;
    cond_replay = 16'h0000;
    // R2 - trace miss qualifier
    cond_branch[`PESM_MB_TRACE_ABSENT] = branch_predictor_fetch_event & trace_lookup_absent;
    // R3 - translation hit kinds
    // R4 - no page size input at all
    cond_transl[`PESM_MB_TR_HIT]    = instr_translation_lookup_event & translation_hit;
    cond_transl[`PESM_MB_TR_MISS]   = instr_translation_lookup_event & translation_miss;
    cond_transl[`PESM_MB_TR_UC_HIT] = instr_translation_lookup_event & uncacheable_translation_found;
    // R7 - store buffer replay
    cond_dcache[`PESM_MB_STBUF_FULL] = store_buffer_exhausted;
    // R8 - aliasing conflict
    cond_dcache[`PESM_MB_ALIAS] = alias_conflict;
    // R11 - cacheable load splits
    cond_split[`PESM_MB_LOAD_SPLIT] = load_split_done & ~load_split_uc_wc;
    // R12 - all split stores
    cond_split[`PESM_MB_STORE_SPLIT] = store_split_done;
    // R13 - split load replay
    cond_replay[`PESM_MB_DIVIDED_LOAD] = divided_load;
  end

  // ****************************************************************
  // per-counter event steering
  // ****************************************************************
  // counters 0-3 sit in the low group, 8-11 in the high group;
  // index k 0-3 is counter k, 4-7 is counter k+4
  for (genvar k = 0; k < `PESM_NUM_CNT; k++) begin : g_cnt
    localparam int HALF = (k % 4) / 2;
    pesm_pkg::pesm_csel_t csel;
    pesm_pkg::pesm_word_t esc;
    pesm_pkg::pesm_code_t code;
    pesm_pkg::pesm_mask_t cond;
    logic                 match;

    always_comb begin
      csel  = cfg_q[k][`PESM_CFG_CSEL_HI:`PESM_CFG_CSEL_LO];
      esc   = `PESM_RESET_WORD;
      cond  = 16'h0000;
      match = 1'b0;
      code  = 7'h00;
      if (k < 4) begin
        if (csel == `PESM_CSEL_BRANCH) begin
          // R1 - branch regs to 0-3
          esc   = sel_q[`PESM_IDX_BRANCH_A + HALF];
          code  = esc[`PESM_SEL_CODE_HI:`PESM_SEL_CODE_LO];
          match = (code == `PESM_CODE_BRANCH_FETCH);
          cond  = cond_branch;
        end else if (csel == `PESM_CSEL_TRANSL) begin
          // R3 - translation regs to 0-3
          esc   = sel_q[`PESM_IDX_TRANSL_A + HALF];
          code  = esc[`PESM_SEL_CODE_HI:`PESM_SEL_CODE_LO];
          match = (code == `PESM_CODE_TRANSL_REF);
          cond  = cond_transl;
        end
      end else begin
        if (csel == `PESM_CSEL_DCACHE) begin
          // R6 - cache address regs to 8-11
          esc   = sel_q[`PESM_IDX_DCACHE_A + HALF];
          code  = esc[`PESM_SEL_CODE_HI:`PESM_SEL_CODE_LO];
          match = (code == `PESM_CODE_DCACHE_CANCEL);
          cond  = cond_dcache;
        end else if (csel == `PESM_CSEL_STADDR) begin
          esc  = sel_q[`PESM_IDX_STADDR_A + HALF];
          code = esc[`PESM_SEL_CODE_HI:`PESM_SEL_CODE_LO];
          // R10 - split completion code
          if (code == `PESM_CODE_SPLIT_DONE) begin
            match = 1'b1;
            cond  = cond_split;
          // R13 - load replay code
          end else if (code == `PESM_CODE_LOAD_REPLAY) begin
            match = 1'b1;
            cond  = cond_replay;
          end
        end
      end
    end

    // R16 - mask bits ored
    assign cnt_inc[k]  = cfg_q[k][`PESM_CFG_ENABLE] & match &
                         (|(esc[`PESM_SEL_MASK_HI:`PESM_SEL_MASK_LO] & cond));
    assign cnt_load[k] = wr_access & in_cnt & (widx == 3'(k));

    pesm_counter u_counter (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (cnt_load[k]),
      .load_val (pwdata),
      .inc      (cnt_inc[k]),
      .count_q  (cnt_q[k]),
      .ovf      (ovf[k])
    );
  end

  // ****************************************************************
  // all cache miss count
  // ****************************************************************
  // R9 - uncacheable accesses included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_q <= `PESM_RESET_WORD;
    end else if (wr_access & at_miss) begin
      miss_q <= pwdata;
    end else if (cache_miss | uncacheable_access) begin
      miss_q <= miss_q + 32'h00000001;
    end
  end

  // ****************************************************************
  // interrupts on counter overflow
  // ****************************************************************
  // set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 8'h00;
    end else if (wr_access & at_status) begin
      irq_status_q <= (irq_status_q & ~pwdata[7:0]) | ovf;
    end else begin
      irq_status_q <= irq_status_q | ovf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 8'h00;
    end else if (wr_access & at_mask) begin
      irq_mask_q <= pwdata[7:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

endmodule // pesm_top

/* File: pesm_top_asserts.sv */
// checker for the register port of the performance event select map
`timescale 1ns/100ps
module pesm_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        irq
);
  // ****************************************************************
  // register port properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bad;
  // map is contiguous up to the all-miss counter
  assign bad = (paddr[1:0] != 2'h0) || (paddr > 12'h068);
  sequence s_acc; psel && penable; endsequence
  sequence s_rd; psel && penable && !pwrite && !bad; endsequence
  sequence s_wr_sel; psel && penable && pwrite && !bad && paddr < 12'h020; endsequence
  sequence s_wr_cfg; psel && penable && pwrite && !bad && paddr >= 12'h020 && paddr < 12'h040; endsequence
  // read setup of the same word one idle cycle after a write
  sequence s_back; psel && !penable && !pwrite && paddr == $past(paddr, 2); endsequence
  property p_sel_rsvd; s_rd ##0 (paddr < 12'h020) |-> prdata[8:0] == 9'h000; endproperty
  property p_cfg_rsvd;
    s_rd ##0 (paddr >= 12'h020 && paddr < 12'h040) |-> prdata[31:16] == 16'h0000 && prdata[11:0] == 12'h000;
  endproperty
  property p_irq_rsvd; s_rd ##0 (paddr >= 12'h060 && paddr < 12'h068) |-> prdata[31:8] == 24'h000000; endproperty
  property p_bad; s_acc ##0 bad |-> pslverr && prdata == 32'h00000000; endproperty
  property p_good; s_acc ##0 !bad |-> !pslverr; endproperty
  property p_irq_fall; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
  property p_sel_wr; s_wr_sel ##2 s_back ##1 s_rd |-> prdata == ($past(pwdata, 3) & 32'hFFFFFE00); endproperty
  property p_cfg_wr; s_wr_cfg ##2 s_back ##1 s_rd |-> prdata == ($past(pwdata, 3) & 32'h0000F000); endproperty
  a_sel_rsvd: assert property (p_sel_rsvd) else $error("select reserved bits not zero");
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config reserved bits not zero");
  a_irq_rsvd: assert property (p_irq_rsvd) else $error("irq register upper bits not zero");
  a_bad: assert property (p_bad) else $error("unmapped access not refused");
  a_good: assert property (p_good) else $error("mapped access refused");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
  a_sel_wr: assert property (p_sel_wr) else $error("select readback wrong");
  a_cfg_wr: assert property (p_cfg_wr) else $error("config readback wrong");
endmodule // pesm_top_chk

bind pesm_top pesm_top_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .irq(irq)
);

/* File: pesm_tb.sv */
// self-checking bench for the performance event select map
`timescale 1ns/100ps
`include "pesm_consts.svh"
module tb;
  typedef struct packed {
    logic [2:0]  k;
    logic [2:0]  idx;
    logic [2:0]  csel;
    logic        en;
    logic [6:0]  code;
    logic [3:0]  mask;
    logic [13:0] ev;
    logic        exp;
  } pesm_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [13:0] ev;
  int          errors, tests_run;
  pesm_row_s   rows [19];
  pesm_row_s   r;

  // ****************************************************************
  // design and tasks
  // ****************************************************************
  // ev bits: fetch absent xlat hit miss ucf stbuf alias lsd lucwc ssd divl cmiss ucacc
  pesm_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .branch_predictor_fetch_event(ev[13]), .trace_lookup_absent(ev[12]),
    .instr_translation_lookup_event(ev[11]), .translation_hit(ev[10]), .translation_miss(ev[9]),
    .uncacheable_translation_found(ev[8]), .store_buffer_exhausted(ev[7]), .alias_conflict(ev[6]),
    .load_split_done(ev[5]), .load_split_uc_wc(ev[4]), .store_split_done(ev[3]), .divided_load(ev[2]),
    .cache_miss(ev[1]), .uncacheable_access(ev[0])
  );
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // slave may stretch the access; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rdat, e);
  endtask
  task automatic pulse(input logic [13:0] v, input int n);
    @(posedge pclk);
    ev <= v;
    repeat (n) @(posedge pclk);
    ev <= 14'h0000;
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task results;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    results();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, errors, tests_run} = '0;
    rows = '{
      '{3'h0, 3'h0, 3'h0, 1'h1, 7'h03, 4'h1, 14'h3000, 1'h1},
      '{3'h2, 3'h1, 3'h0, 1'h1, 7'h03, 4'h1, 14'h3000, 1'h1},
      '{3'h1, 3'h0, 3'h0, 1'h1, 7'h03, 4'h1, 14'h2000, 1'h0},
      '{3'h0, 3'h0, 3'h3, 1'h1, 7'h03, 4'h1, 14'h3000, 1'h0},
      '{3'h0, 3'h2, 3'h3, 1'h1, 7'h18, 4'h1, 14'h0C00, 1'h1},
      '{3'h3, 3'h3, 3'h3, 1'h1, 7'h18, 4'h2, 14'h0A00, 1'h1},
      '{3'h1, 3'h2, 3'h3, 1'h1, 7'h18, 4'h4, 14'h0900, 1'h1},
      '{3'h1, 3'h2, 3'h3, 1'h1, 7'h18, 4'h1, 14'h0A00, 1'h0},
      '{3'h0, 3'h2, 3'h3, 1'h1, 7'h18, 4'h7, 14'h0A00, 1'h1},
      '{3'h0, 3'h2, 3'h3, 1'h0, 7'h18, 4'h7, 14'h0A00, 1'h0},
      '{3'h4, 3'h4, 3'h5, 1'h1, 7'h02, 4'h4, 14'h0080, 1'h1},
      '{3'h6, 3'h5, 3'h5, 1'h1, 7'h02, 4'h8, 14'h0040, 1'h1},
      '{3'h5, 3'h4, 3'h5, 1'h1, 7'h02, 4'h8, 14'h0080, 1'h0},
      '{3'h4, 3'h4, 3'h5, 1'h1, 7'h08, 4'h4, 14'h0080, 1'h0},
      '{3'h0, 3'h4, 3'h5, 1'h1, 7'h02, 4'h4, 14'h0080, 1'h0},
      '{3'h4, 3'h6, 3'h2, 1'h1, 7'h08, 4'h1, 14'h0020, 1'h1},
      '{3'h4, 3'h6, 3'h2, 1'h1, 7'h08, 4'h1, 14'h0030, 1'h0},
      '{3'h7, 3'h7, 3'h2, 1'h1, 7'h08, 4'h2, 14'h0008, 1'h1},
      '{3'h6, 3'h7, 3'h2, 1'h1, 7'h04, 4'h2, 14'h0004, 1'h1}
    };
    do_reset();
    for (int i = 0; i < 19; i++) begin
      r = rows[i];
      apb(1'b1, 12'h040 + {7'h00, r.k, 2'h0}, 32'h00000000);
      apb(1'b1, {7'h00, r.idx, 2'h0}, {r.code, 12'h000, r.mask, 9'h000});
      apb(1'b1, 12'h020 + {7'h00, r.k, 2'h0}, {16'h0000, r.csel, r.en, 12'h000});
      pulse(r.ev, 1);
      rd(12'h040 + {7'h00, r.k, 2'h0}, {31'h00000000, r.exp});
      $display("row %0d done", i);
    end
    // second reset in mid-run clears every register
    do_reset();
    for (int a = 0; a < 27; a++) rd(12'(a * 4), 32'h00000000);
    $display("reset test done");
    apb(1'b1, 12'h01C, 32'hFFFFFFFF);
    rd(12'h01C, `PESM_SEL_WR_MASK);
    apb(1'b1, 12'h03C, 32'hFFFFFFFF);
    rd(12'h03C, `PESM_CFG_WR_MASK);
    apb(1'b1, 12'h002, 32'hFFFFFFFF);
    chk({31'h00000000, rerr}, 32'h00000001);
    rd(12'h000, 32'h00000000);
    apb(1'b0, 12'h06C, 32'h00000000);
    chk({31'h00000000, rerr}, 32'h00000001);
    chk(rdat, 32'h00000000);
    $display("field test done");
    pulse(14'h0003, 1);
    pulse(14'h0001, 1);
    pulse(14'h0002, 1);
    rd(12'h068, 32'h00000003);
    $display("all-miss test done");
    apb(1'b1, 12'h000, {7'h03, 12'h000, 4'h1, 9'h000});
    apb(1'b1, 12'h020, 32'h00001000);
    apb(1'b1, 12'h040, 32'hFFFFFFFF);
    pulse(14'h3000, 1);
    rd(12'h040, 32'h00000000);
    rd(12'h060, 32'h00000001);
    apb(1'b1, 12'h064, 32'h00000001);
    @(negedge pclk);
    chk({31'h00000000, irq}, 32'h00000001);
    apb(1'b1, 12'h060, 32'h00000001);
    @(negedge pclk);
    chk({31'h00000000, irq}, 32'h00000000);
    rd(12'h060, 32'h00000000);
    // held level counts once per cycle
    pulse(14'h3000, 3);
    rd(12'h040, 32'h00000003);
    $display("overflow test done");
    results();
  end
endmodule // tb
